// [logic/counter_timer_card.v]
// three-channel counter/timer card: port decode, clock ranges, gating, status
//
// Contract
// RL1: rl=11 channel waits for both preload bytes
// RL2: first byte low half, second byte high
// RL3: counting starts when second byte written
// RL4: channel 1 loads through single port d9
// RL5: mode 0 keeps decrementing past terminal count
// RL6: gate still pauses counting after terminal count
// RL7: latch command gives tear-free count reads
// RL8: software gate bit one enables, zero halts
// RL9: count only while gate at programmed polarity
// RL10: status bits 6,7 show spare inputs
// RL11: status write ones clear matching latches only
// RL12: each channel latch readable as status bit
// RL13: down counting only, zero ffff or 9999
// RL14: event inputs accepted up to 2.5 mhz
// RL15: event from pin or host port read
// RL16: host preloads first use after mode select
// RL17: limit count raises interrupt at terminal count
// RL18: selection 6 cascades previous channel output
// RL19: wrap below zero to ffff or 9999
`timescale 1ns/1ps
`include "ctc_defines.vh"

module counter_timer_card
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // host i/o bus, strobes one cycle wide
   input  wire [7:0]  io_addr,
   input  wire [7:0]  io_wdata,
   input  wire        io_wr,
   input  wire        io_rd,
   output reg  [7:0]  io_rdata,
   // field pins, asynchronous
   input  wire [2:0]  event_in,
   input  wire [2:0]  gate_in,
   input  wire [1:0]  spare_in,
   // channel outputs and interrupt request
   output wire [2:0]  chan_out,
   output reg         int_req
);

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   // three stages; a level is accepted once stages two and three agree
   reg  [7:0]  pin_s1_reg;       // first stage, feeds only the second
   reg  [7:0]  pin_s2_reg;       // second stage
   reg  [7:0]  pin_s3_reg;       // third stage
   reg  [7:0]  pin_ok_reg;       // accepted level
   reg  [2:0]  event_prev_reg;   // accepted event level, one cycle old

   wire [7:0]  pin_raw   = {spare_in, gate_in, event_in};
   wire [2:0]  event_ok  = pin_ok_reg[2:0];
   wire [2:0]  gate_ok   = pin_ok_reg[5:3];
   wire [1:0]  spare_ok  = pin_ok_reg[7:6];
   // rising event edge; 2.5 mhz leaves 5 clocks per half period, enough
   // for the 3-stage filter, which also takes levels as short as two clocks
   wire [2:0]  event_edge = event_ok & ~event_prev_reg;          // [RL14]

   always @(posedge clk)
   begin
      if (rst)
      begin
         pin_s1_reg     <= 8'h00;
         pin_s2_reg     <= 8'h00;
         pin_s3_reg     <= 8'h00;
         pin_ok_reg     <= 8'h00;
         event_prev_reg <= 3'h0;
      end
      else
      begin
         pin_s1_reg     <= pin_raw;
         pin_s2_reg     <= pin_s1_reg;
         pin_s3_reg     <= pin_s2_reg;
         // accept each bit only where the later two stages agree
         pin_ok_reg     <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                         | (pin_ok_reg & (pin_s2_reg ^ pin_s3_reg));
         event_prev_reg <= event_ok;
      end
   end

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   wire        mode_hit   = (io_addr == `PORT_MODE);
   wire        status_hit = (io_addr == `PORT_STATUS);
   wire [1:0]  mode_ch    = io_wdata[`MODE_CH_HI:`MODE_CH_LO];
   wire [2:0]  load_hit;                  // per-channel load port hit
   wire [2:0]  ctrl_hit;                  // per-channel control port hit
   wire [23:0] rd_bytes;                  // per-channel read bytes

   assign load_hit[0] = (io_addr == `PORT_LOAD0);
   assign load_hit[1] = (io_addr == `PORT_LOAD1);                // [RL4]
   assign load_hit[2] = (io_addr == `PORT_LOAD2);
   assign ctrl_hit[0] = (io_addr == `PORT_CTRL0);
   assign ctrl_hit[1] = (io_addr == `PORT_CTRL1);
   assign ctrl_hit[2] = (io_addr == `PORT_CTRL2);

   // ----------------------------------------------------------------------
   // channel control ports
   // ----------------------------------------------------------------------
   reg  [7:0]  ctrl_mem [0:2];            // gate, polarity, irq enable, range
   integer     ci;

   // control ports are write only; reading one is the software event
   always @(posedge clk)
   begin
      if (rst)
      begin
         for (ci = 0; ci < 3; ci = ci + 1)
            ctrl_mem[ci] <= `CTRL_RST;
      end
      else
      begin
         for (ci = 0; ci < 3; ci = ci + 1)
            if (io_wr && ctrl_hit[ci])
               ctrl_mem[ci] <= io_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // clock range prescaler
   // ----------------------------------------------------------------------
   reg  [`PRESC_W-1:0] presc_reg;         // free running divider
   reg  [2:0]          tc_prev_reg;       // channel outputs, one cycle old

   always @(posedge clk)
   begin
      if (rst)
         presc_reg <= {`PRESC_W{1'b0}};
      else
         presc_reg <= presc_reg + {{(`PRESC_W-1){1'b0}}, 1'b1};
   end

   wire [4:0]  range_tick;                // one pulse per range period
   assign range_tick[0] = &presc_reg[`TAP0:0];
   assign range_tick[1] = &presc_reg[`TAP1:0];
   assign range_tick[2] = &presc_reg[`TAP2:0];
   assign range_tick[3] = &presc_reg[`TAP3:0];
   assign range_tick[4] = &presc_reg[`TAP4:0];

   wire [2:0]  tc_rise = chan_out & ~tc_prev_reg;

   // ----------------------------------------------------------------------
   // per-channel count source, gating and counter
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : chan
         wire [2:0] sel = ctrl_mem[g][`CTRL_SEL_HI:`CTRL_SEL_LO];
         // gate level matches the programmed polarity
         wire gate_act  = ctrl_mem[g][`CTRL_GPOL] ? gate_ok[g]
                                                  : ~gate_ok[g];        // [RL9]
         wire enable    = ctrl_mem[g][`CTRL_GATE] & gate_act;           // [RL8]
         reg  tick;

         // count source multiplexer
         always @*
         begin
            case (sel)
               `SEL_SOFT:    tick = io_rd & ctrl_hit[g];                // [RL15]
               `SEL_CASCADE: tick = tc_rise[(g + 2) % 3];               // [RL18]
               `SEL_EXT:     tick = event_edge[g];                      // [RL15]
               3'h0:         tick = range_tick[0];
               3'h1:         tick = range_tick[1];
               3'h2:         tick = range_tick[2];
               3'h3:         tick = range_tick[3];
               3'h4:         tick = range_tick[4];
               default:      tick = 1'b0;
            endcase
         end

         count_channel u_chan
         (
            .clk       (clk),
            .rst       (rst),
            .mode_wr   (io_wr & mode_hit & (mode_ch == g)),
            .load_wr   (io_wr & load_hit[g]),                           // [RL4]
            .rd_strobe (io_rd & load_hit[g]),
            .wr_data   (io_wdata),
            .rd_byte   (rd_bytes[g*8 +: 8]),
            .count_en  (tick & enable),                                 // [RL6]
            .tc_out    (chan_out[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // interrupt latches
   // ----------------------------------------------------------------------
   reg  [2:0]  int_latch_reg;             // sticky terminal-count flags
   wire [2:0]  int_en = {ctrl_mem[2][`CTRL_IEN], ctrl_mem[1][`CTRL_IEN],
                         ctrl_mem[0][`CTRL_IEN]};
   wire [2:0]  int_set = tc_rise & int_en;                              // [RL17]
   wire [2:0]  int_clr = (io_wr && status_hit) ? io_wdata[2:0] : 3'h0;

   // a set in the same cycle as its clear wins, so no event is lost
   always @(posedge clk)
   begin
      if (rst)
      begin
         int_latch_reg <= 3'h0;
         tc_prev_reg   <= 3'h0;
         int_req       <= 1'b0;
      end
      else
      begin
         int_latch_reg <= (int_latch_reg & ~int_clr) | int_set;        // [RL11]
         tc_prev_reg   <= chan_out;
         int_req       <= |((int_latch_reg & ~int_clr) | int_set);
      end
   end

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   // answered one cycle after the read strobe, held until the next read
   always @(posedge clk)
   begin
      if (rst)
         io_rdata <= 8'h00;
      else if (io_rd)
      begin
         if (status_hit)
            io_rdata <= {spare_ok, 3'h0, int_latch_reg};          // [RL10] [RL12]
         else if (load_hit[0])
            io_rdata <= rd_bytes[7:0];
         else if (load_hit[1])
            io_rdata <= rd_bytes[15:8];
         else if (load_hit[2])
            io_rdata <= rd_bytes[23:16];
         else
            io_rdata <= 8'h00;
      end
   end

endmodule

// [logic/ctc_defines.vh]
// constants for the three-channel counter/timer card
`ifndef CTC_DEFINES_VH
`define CTC_DEFINES_VH

// ----------------------------------------------------------------------
// i/o port addresses
// ----------------------------------------------------------------------
`define PORT_LOAD0      8'hd8
`define PORT_LOAD1      8'hd9
`define PORT_LOAD2      8'hda
`define PORT_MODE       8'hdb
`define PORT_CTRL0      8'hdc
`define PORT_CTRL1      8'hdd
`define PORT_CTRL2      8'hde
`define PORT_STATUS     8'hdf

// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define MODE_CH_HI      7
`define MODE_CH_LO      6
`define MODE_RL_HI      5
`define MODE_RL_LO      4
`define MODE_MD_HI      3
`define MODE_MD_LO      1
`define MODE_BCD        0
`define RL_LATCH        2'h0
`define RL_LSB          2'h1
`define RL_MSB          2'h2
`define RL_BOTH         2'h3
`define MODE_RST        8'h30

// ----------------------------------------------------------------------
// channel control port fields
// ----------------------------------------------------------------------
`define CTRL_GATE       0
`define CTRL_GPOL       1
`define CTRL_IEN        2
`define CTRL_SEL_HI     6
`define CTRL_SEL_LO     4
`define CTRL_RST        8'h00
`define SEL_SOFT        3'h5
`define SEL_CASCADE     3'h6
`define SEL_EXT         3'h7

// ----------------------------------------------------------------------
// prescaler taps (clock ranges), status layout, count references
// ----------------------------------------------------------------------
`define PRESC_W         16
`define TAP0            3
`define TAP1            6
`define TAP2            9
`define TAP3            12
`define TAP4            15
`define STAT_SPARE_LO   6
`define ZERO_BIN        16'hffff
`define ZERO_BCD        16'h9999
`define COUNT_ONE       16'h0001

`endif

// [logic/count_channel.v]
// one 16-bit down-counting channel with preload, latch and terminal count
`timescale 1ns/1ps
`include "ctc_defines.vh"

module count_channel
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // host access, already decoded for this channel
   input  wire        mode_wr,
   input  wire        load_wr,
   input  wire        rd_strobe,
   input  wire [7:0]  wr_data,
   output reg  [7:0]  rd_byte,
   // counting
   input  wire        count_en,
   output reg         tc_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg  [7:0]  mode_reg;      // rl, mode and bcd fields
   reg  [7:0]  low_byte_reg;  // first preload byte waiting for the second
   reg  [15:0] count_reg;     // live count
   reg  [15:0] latch_reg;     // frozen count for tear-free reads
   reg         latched_reg;   // latch holds a value not yet read out
   reg         armed_reg;     // preload complete, counting allowed
   reg         wr_hi_reg;     // next load byte is the high byte
   reg         rd_hi_reg;     // next read byte is the high byte

   wire [1:0]  rl   = mode_reg[`MODE_RL_HI:`MODE_RL_LO];
   wire        bcd  = mode_reg[`MODE_BCD];
   wire [15:0] src  = latched_reg ? latch_reg : count_reg;

   // ----------------------------------------------------------------------
   // decrement, binary or four bcd digits
   // ----------------------------------------------------------------------
   // a zero count wraps to the zero reference so totalizing keeps going
   function [15:0] dec_count;
      input [15:0] v;
      input        is_bcd;
      reg   [15:0] r;
      reg          borrow;
      integer      i;
      begin
         r      = v;
         borrow = 1'b1;
         if (!is_bcd)
            r = v - `COUNT_ONE;                                   // [RL13] [RL19]
         else
            for (i = 0; i < 4; i = i + 1)
            begin
               if (borrow)
               begin
                  if (v[i*4 +: 4] == 4'h0)
                     r[i*4 +: 4] = 4'h9;                          // [RL19]
                  else
                  begin
                     r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                     borrow      = 1'b0;
                  end
               end
            end
         dec_count = r;
      end
   endfunction

   // ----------------------------------------------------------------------
   // read byte select
   // ----------------------------------------------------------------------
   always @*
   begin
      if (rl == `RL_MSB || (rl == `RL_BOTH && rd_hi_reg))
         rd_byte = src[15:8];
      else
         rd_byte = src[7:0];
   end

   // ----------------------------------------------------------------------
   // mode, preload, count and latch
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg     <= `MODE_RST;
         low_byte_reg <= 8'h00;
         count_reg    <= 16'h0000;
         latch_reg    <= 16'h0000;
         latched_reg  <= 1'b0;
         armed_reg    <= 1'b0;
         wr_hi_reg    <= 1'b0;
         rd_hi_reg    <= 1'b0;
         tc_out       <= 1'b0;
      end
      else
      begin
         // counting first; a load that writes count_reg in the same cycle overrides it below
         if (armed_reg && count_en)
         begin
            count_reg <= dec_count(count_reg, bcd);               // [RL5] [RL6]
            if (count_reg == `COUNT_ONE)
               tc_out <= 1'b1;                                    // [RL17]
         end
         if (mode_wr)
         begin
            if (wr_data[`MODE_RL_HI:`MODE_RL_LO] == `RL_LATCH)
            begin
               // latch command: freeze once, ignore until read out
               if (!latched_reg)
               begin
                  latch_reg   <= count_reg;                       // [RL7]
                  latched_reg <= 1'b1;
               end
               rd_hi_reg <= 1'b0;
            end
            else
            begin
               // new mode: stop until preloaded again
               mode_reg    <= wr_data;
               armed_reg   <= 1'b0;                               // [RL1]
               wr_hi_reg   <= 1'b0;
               rd_hi_reg   <= 1'b0;
               latched_reg <= 1'b0;
               tc_out      <= 1'b0;
            end
         end
         else if (load_wr)
         begin
            case (rl)
               `RL_BOTH:
               begin
                  if (!wr_hi_reg)
                  begin
                     low_byte_reg <= wr_data;                     // [RL2]
                     wr_hi_reg    <= 1'b1;
                     armed_reg    <= 1'b0;                        // [RL1]
                  end
                  else
                  begin
                     count_reg <= {wr_data, low_byte_reg};        // [RL2]
                     wr_hi_reg <= 1'b0;
                     armed_reg <= 1'b1;                           // [RL3]
                     tc_out    <= 1'b0;
                  end
               end
               `RL_MSB:
               begin
                  count_reg <= {wr_data, 8'h00};
                  armed_reg <= 1'b1;
                  tc_out    <= 1'b0;
               end
               default:
               begin
                  count_reg <= {8'h00, wr_data};
                  armed_reg <= 1'b1;
                  tc_out    <= 1'b0;
               end
            endcase
         end
         else if (rd_strobe)
         begin
            // the latch lets go after its last byte has been read
            if (rl == `RL_BOTH)
            begin
               rd_hi_reg <= ~rd_hi_reg;
               if (rd_hi_reg)
                  latched_reg <= 1'b0;                            // [RL7]
            end
            else
               latched_reg <= 1'b0;
         end
      end
   end

endmodule

// [tb/card_assertions.sv]
// port-level checks for the counter/timer card
`timescale 1ns/1ps
module card_assertions
(
   // clock and reset
   input wire       clk,
   input wire       rst,
   // host bus
   input wire [7:0] io_addr,
   input wire [7:0] io_wdata,
   input wire       io_wr,
   input wire       io_rd,
   input wire [7:0] io_rdata,
   // card outputs
   input wire [2:0] chan_out,
   input wire       int_req
);
   // ---------------------------------------------
   // sequences and checks
   // ---------------------------------------------
   wire clr_wr = io_wr && io_addr == 8'hdf;   // status write
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // mode write to channel 1 asking for both bytes
   sequence s_mode1;
      io_wr && io_addr == 8'hdb && io_wdata[7:4] == 4'h7;
   endsequence
   sequence s_stat_rd;
      io_rd && io_addr == 8'hdf;
   endsequence
   // no output edge lately, so no latch can be set meanwhile
   sequence s_quiet_out;
      $stable(chan_out) && $past(chan_out) == $past(chan_out, 2);
   endsequence
   a_mode_disarm: assert property (s_mode1 |=> !chan_out[1] [*2])
      else $error("channel output high after mode write");
   a_unmapped_rd: assert property (io_rd && (io_addr < 8'hd8 || io_addr == 8'hdb)
      |=> io_rdata == 8'h00) else $error("unmapped read not zero");
   a_ctrl_rd_zero: assert property (io_rd && io_addr >= 8'hdc && io_addr <= 8'hde
      |=> io_rdata == 8'h00) else $error("control read not zero");
   a_status_gap: assert property (s_stat_rd |=> io_rdata[5:3] == 3'h0)
      else $error("status unused bits set");
   a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without a read");
   a_clear_all: assert property (clr_wr && io_wdata[2:0] == 3'h7 ##0 s_quiet_out
      |=> ##1 !int_req) else $error("interrupt kept after clearing all");
   a_int_cause: assert property ($rose(int_req)
      |-> ($past(chan_out) | $past(chan_out, 2) | $past(chan_out, 3)) != 3'h0)
      else $error("interrupt without terminal count");
   a_int_sticky: assert property (int_req && !clr_wr && !$past(clr_wr) |=> int_req)
      else $error("interrupt dropped without a clear");
endmodule

bind counter_timer_card card_assertions chk (.clk(clk), .rst(rst), .io_addr(io_addr),
   .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
   .chan_out(chan_out), .int_req(int_req));

// [tb/host_io_model.sv]
// host processor model driving the card's i/o port bus
`timescale 1ns/1ps
module host_io_model
(
   // clock
   input wire       clk,
   // i/o bus toward the card
   output reg [7:0] io_addr,
   output reg [7:0] io_wdata,
   output reg       io_wr,
   output reg       io_rd
);
   // idle bus at time zero
   initial
   begin
      io_addr = 8'h00;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end
   // one access held across one sampling edge, then released
   task access(input [7:0] a, input [7:0] d, input w);
   begin
      @(posedge clk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = w;
      io_rd = !w;
      @(posedge clk);
      #1;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = ~a;     // released bus must not look stable
      io_wdata = ~d;
   end
   endtask
   // preload a channel, low byte first and high byte last
   task load16(input [7:0] a, input [15:0] v);
   begin
      access(a, v[7:0], 1'b1);
      access(a, v[15:8], 1'b1);
   end
   endtask
endmodule

// [tb/three_channel_counter_timer_card_bench.sv]
// self-checking bench for the counter/timer card
`timescale 1ns/1ps
module three_channel_counter_timer_card_bench;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   reg          clk;          // 25 mhz
   reg          rst;          // synchronous, active high
   reg  [2:0]   event_in;     // field event pins
   reg  [2:0]   gate_in;      // field gate pins
   reg  [1:0]   spare_in;     // spare inputs
   wire [7:0]   io_addr;      // bus from the host model
   wire [7:0]   io_wdata;
   wire         io_wr;
   wire         io_rd;
   wire [7:0]   io_rdata;     // card answer
   wire [2:0]   chan_out;     // terminal count levels
   wire         int_req;      // interrupt request
   logic [7:0]  exp_q[$];     // expected read bytes, oldest first
   logic [15:0] r_val;        // random preload
   int          mismatches;
   int          comparisons;
   reg          took;         // read taken at this edge
   reg          pend;         // answer due at this edge
   host_io_model host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
      .io_rd(io_rd));
   counter_timer_card dut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .event_in(event_in),
      .gate_in(gate_in), .spare_in(spare_in), .chan_out(chan_out), .int_req(int_req));
   initial
   begin
      clk = 1'b0;
   end
   always #20 clk = ~clk;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
   begin
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   end
   endtask
   task cyc(input int n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      host.access(a, d, 1'b1);
   endtask
   // read, noting the byte the monitor must see
   task rd(input [7:0] a, input [7:0] e);
   begin
      exp_q.push_back(e);
      host.access(a, 8'h00, 1'b0);
   end
   endtask
   // latch command for the channel, then low and high byte
   task rd16(input [7:0] a, input [15:0] e);
   begin
      wr(8'hdb, {a[1:0], 6'h00});
      rd(a, e[7:0]);
      rd(a, e[15:8]);
   end
   endtask
   // one event at 2.5 mhz: five cycles high, five low
   task pulse;
   begin
      event_in[0] = 1'b1;
      cyc(5);
      event_in[0] = 1'b0;
      cyc(5);
   end
   endtask
   task print_verdict;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   // monitor: answer lands one cycle after the read edge
   always @(posedge clk)
   begin
      took = io_rd;
      #2;
      if (pend)
         chk("io_rdata", {8'h00, exp_q.pop_front()}, {8'h00, io_rdata});
      pend = took;
   end
   // watchdog, far beyond the couple of hundred cycles needed
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict;
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial
   begin
      mismatches = 0;
      comparisons = 0;
      pend = 1'b0;
      took = 1'b0;
      r_val = $urandom(32'hba7f2bb2);
      spare_in = $urandom;
      gate_in = {$urandom, 2'b11};
      event_in = 3'h0;
      rst = 1'b1;
      cyc(8);
      rst = 1'b0;
      wr(8'hdb, 8'h70);
      wr(8'hdd, 8'h57);                           // host-read ticks, interrupt on
      wr(8'hd9, 8'h02);
      rd(8'hdd, 8'h00);
      wr(8'hd9, 8'h00);
      rd16(8'hd9, 16'h0002);
      rd(8'h10, 8'h00);
      rd(8'hdd, 8'h00);
      rd(8'hdd, 8'h00);
      cyc(6);
      chk("chan_out", 16'h2, {13'h0, chan_out});
      chk("int_req", 16'h1, {15'h0, int_req});
      rd(8'hdf, {spare_in, 6'h02});
      rd(8'hdd, 8'h00);
      rd16(8'hd9, 16'hffff);
      $display("test preload and terminal count done");
      wr(8'hdf, 8'h05);
      cyc(3);
      chk("int_req", 16'h1, {15'h0, int_req});
      wr(8'hdf, 8'h07);
      cyc(3);
      chk("int_req", 16'h0, {15'h0, int_req});
      rd(8'hdf, {spare_in, 6'h00});
      $display("test status clear done");
      wr(8'hdd, 8'h56);
      rd(8'hdd, 8'h00);
      rd16(8'hd9, 16'hffff);
      wr(8'hdd, 8'h55);
      rd(8'hdd, 8'h00);
      rd16(8'hd9, 16'hffff);
      gate_in[1] = 1'b0;
      cyc(5);
      rd(8'hdd, 8'h00);
      rd16(8'hd9, 16'hfffe);
      $display("test gating done");
      gate_in[1] = 1'b1;
      wr(8'hdd, 8'h56);
      wr(8'hdb, 8'h70);
      host.load16(8'hd9, r_val);
      rd16(8'hd9, r_val);
      wr(8'hdb, 8'h71);
      wr(8'hdd, 8'h57);
      host.load16(8'hd9, 16'h0000);
      rd(8'hdd, 8'h00);
      rd16(8'hd9, 16'h9999);
      $display("test random preload and decimal wrap done");
      wr(8'hdb, 8'h30);
      wr(8'hdc, 8'h77);                           // pin events, interrupt on
      host.load16(8'hd8, 16'h0003);
      wr(8'hdb, 8'h70);
      wr(8'hdd, 8'h67);                           // channel 1 cascaded from 0
      host.load16(8'hd9, 16'h0001);
      repeat (3) pulse;
      cyc(8);
      chk("chan_out", 16'h3, {13'h0, chan_out});
      rd16(8'hd9, 16'h0000);
      chk("int_req", 16'h1, {15'h0, int_req});
      rd16(8'hd8, 16'h0000);
      $display("test pin events done");
      cyc(3);
      print_verdict;
   end
endmodule
